// File: aux_sysreg_walk_attr_bank.sv
// Auxiliary register bank with walk attribute control behind an APB slave.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "aux_bank_map.svh"
module aux_sysreg_walk_attr_bank #(
	parameter int ADDR_W = 8
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ADDR_W-1:0]          paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	input  wire logic                       attr_support_pin,
	input  wire aux_bank_pkg::ctl_wr_req_s  ctl_wr_req,
	output logic                            ctl_wr_allow,
	output logic                            ctl_wr_block,
	input  wire aux_bank_pkg::walk_req_s    walk_req,
	output aux_bank_pkg::walk_attr_s        walk_attr
);
	import aux_bank_pkg::*;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] a);
		reg_sel_e s;
		s = SEL_NONE;
		case (a)
			`OFS_AUXC_LO: s = SEL_AUXC_LO;
			`OFS_AUXC_HI: s = SEL_AUXC_HI;
			`OFS_AFS0_L1, `OFS_AFS0_L2, `OFS_AFS0_L3,
			`OFS_AFS1_L1, `OFS_AFS1_L2, `OFS_AFS1_L3: s = SEL_FAULT;
			`OFS_AIDR: s = SEL_IDENT;
			`OFS_AMA_L1_LO, `OFS_AMA_L1_HI,
			`OFS_AMA_L2_LO, `OFS_AMA_L2_HI,
			`OFS_AMA_L3_LO, `OFS_AMA_L3_HI: s = SEL_INDIRECT;
			`OFS_WALK_LO: s = SEL_WALK_LO;
			`OFS_WALK_HI: s = SEL_WALK_HI;
			`OFS_STATUS: s = SEL_STATUS;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction : decode_reg

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge_strb

	function automatic logic attr_bit(input logic [31:0] c,
		input table_base_e base, input int idx);
		logic v;
		logic e;
		if (base == BASE1) begin
			v = (idx == 1) ? c[`WALK_B1A1_VAL] : c[`WALK_B1A0_VAL];
			e = (idx == 1) ? c[`WALK_B1A1_EN] : c[`WALK_B1A0_EN];
		end else begin
			v = (idx == 1) ? c[`WALK_B0A1_VAL] : c[`WALK_B0A0_VAL];
			e = (idx == 1) ? c[`WALK_B0A1_EN] : c[`WALK_B0A0_EN];
		end
		return v & e;
	endfunction : attr_bit

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	reg_sel_e    sel;
	logic        setup;
	logic        access;
	logic        wr_access;
	logic [31:0] aux_ctrl_q;
	logic [31:0] aux_ctrl_d;
	logic [31:0] walk_ctrl_q;
	logic [31:0] walk_ctrl_d;
	logic [31:0] rdata_d;
	logic        cfg_meta_q;
	logic        cfg_q;
	logic        block_seen_q;
	logic [1:0]  attr_d;
	walk_attr_s  walk_attr_q;

	assign sel       = decode_reg(paddr);
	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign wr_access = access & pwrite;

	// The slave never inserts wait states: every access completes in the
	// first access cycle, so read data is fetched during setup.
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// Attribute support pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_meta_q <= 1'b0;
			cfg_q      <= 1'b0;
		end else begin
			cfg_meta_q <= attr_support_pin;
			cfg_q      <= cfg_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Highest-level auxiliary control register
	// ----------------------------------------------------------------
	always_comb begin
		aux_ctrl_d = aux_ctrl_q;
		if (wr_access && sel == SEL_AUXC_LO) begin
			aux_ctrl_d = merge_strb(aux_ctrl_q, pwdata, pstrb) & `AUXC_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_ctrl_q <= `AUXC_RST;
		end else begin
			aux_ctrl_q <= aux_ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// Walk attribute control register
	// ----------------------------------------------------------------
	always_comb begin
		walk_ctrl_d = walk_ctrl_q;
		if (wr_access && sel == SEL_WALK_LO) begin
			walk_ctrl_d = merge_strb(walk_ctrl_q, pwdata, pstrb) & `WALK_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			walk_ctrl_q <= `WALK_RST;
		end else begin
			walk_ctrl_q <= walk_ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// Read data and error response
	// ----------------------------------------------------------------
	always_comb begin
		rdata_d = `ZERO_WORD;
		case (sel)
			SEL_AUXC_LO: rdata_d = aux_ctrl_q;
			SEL_FAULT: rdata_d = `ZERO_WORD;
			SEL_IDENT: rdata_d = `ZERO_WORD;
			SEL_INDIRECT: rdata_d = `ZERO_WORD;
			SEL_WALK_LO: rdata_d = walk_ctrl_q;
			SEL_WALK_HI: rdata_d = `ZERO_WORD;
			SEL_STATUS: begin
				rdata_d[`STAT_CFG_BIT] = cfg_q;
				rdata_d[`STAT_ATTR_LSB +: 2] = walk_attr_q.page_hw_attributes;
				rdata_d[`STAT_BLOCK_BIT] = block_seen_q;
			end
			default: rdata_d = `ZERO_WORD;
		endcase
	end

	// Writes to read-only and reserved words are dropped quietly; only an
	// address outside the map answers with an error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `ZERO_WORD;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? `ZERO_WORD : rdata_d;
			pslverr <= (sel == SEL_NONE);
		end
	end

	// ----------------------------------------------------------------
	// Control register write gate
	// ----------------------------------------------------------------
	ctl_write_gate u_gate (
		.aux_ctrl_write_enable (aux_ctrl_q[`AUXC_AUX_EN_BIT]),
		.ext_ctrl_write_enable (aux_ctrl_q[`AUXC_EXT_EN_BIT]),
		.req                   (ctl_wr_req),
		.allow                 (ctl_wr_allow),
		.block                 (ctl_wr_block)
	);

	// Last verdict of the gate, visible in the status word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_seen_q <= 1'b0;
		end else if (ctl_wr_req.valid) begin
			block_seen_q <= ctl_wr_block;
		end
	end

	// ----------------------------------------------------------------
	// Page table walk attributes
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_attr
		assign attr_d[i] = cfg_q & attr_bit(walk_ctrl_q, walk_req.base, i);
	end

	// A walk answer is one cycle late; the control word is sampled at the
	// request edge, so a write in the same cycle affects the next walk.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			walk_attr_q <= '0;
		end else begin
			walk_attr_q.valid <= walk_req.valid;
			if (walk_req.valid) begin
				walk_attr_q.page_hw_attributes <= attr_d;
			end
		end
	end

	assign walk_attr = walk_attr_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic mid_req;
	logic aux_tgt;
	logic ext_tgt;
	logic b1a1_exp;
	logic b1a0_exp;
	logic b0a1_exp;
	logic b0a0_exp;

	assign mid_req  = ctl_wr_req.valid &&
		(ctl_wr_req.level == LVL_HYP || ctl_wr_req.level == LVL_KERNEL_S);
	assign aux_tgt  = ctl_wr_req.target == TGT_CORE_AUX ||
		ctl_wr_req.target == TGT_CORE_AUX_SECOND ||
		ctl_wr_req.target == TGT_CLUSTER_AUX;
	assign ext_tgt  = ctl_wr_req.target == TGT_CORE_EXT ||
		ctl_wr_req.target == TGT_CLUSTER_EXT;
	assign b1a1_exp = walk_ctrl_q[`WALK_B1A1_VAL] & walk_ctrl_q[`WALK_B1A1_EN];
	assign b1a0_exp = walk_ctrl_q[`WALK_B1A0_VAL] & walk_ctrl_q[`WALK_B1A0_EN];
	assign b0a1_exp = walk_ctrl_q[`WALK_B0A1_VAL] & walk_ctrl_q[`WALK_B0A1_EN];
	assign b0a0_exp = walk_ctrl_q[`WALK_B0A0_VAL] & walk_ctrl_q[`WALK_B0A0_EN];

	a_aux_write_block: assert property (
		mid_req && aux_tgt && !aux_ctrl_q[`AUXC_AUX_EN_BIT] |-> ctl_wr_block && !ctl_wr_allow
	) else $error("aux control write not blocked");

	a_aux_write_permit: assert property (
		mid_req && aux_tgt && aux_ctrl_q[`AUXC_AUX_EN_BIT] |-> ctl_wr_allow && !ctl_wr_block
	) else $error("aux control write not permitted after enable");

	a_ext_write_block: assert property (
		mid_req && ext_tgt && !aux_ctrl_q[`AUXC_EXT_EN_BIT] |-> ctl_wr_block && !ctl_wr_allow
	) else $error("extended control write not blocked");

	a_ext_write_permit: assert property (
		mid_req && ext_tgt && aux_ctrl_q[`AUXC_EXT_EN_BIT] |-> ctl_wr_allow && !ctl_wr_block
	) else $error("extended control write not permitted");

	a_fault_reads_zero: assert property (
		setup && !pwrite && sel == SEL_FAULT |=> prdata == `ZERO_WORD && !pslverr
	) else $error("fault status read not zero");

	a_ident_reads_zero: assert property (
		setup && sel == SEL_IDENT ##1 access |-> prdata == `ZERO_WORD && !pslverr
	) else $error("identification read not zero");

	a_indirect_reads_zero: assert property (
		setup && !pwrite && sel == SEL_INDIRECT |=> prdata == `ZERO_WORD && !pslverr
	) else $error("indirection read not zero");

	a_walk_unconfigured: assert property (
		walk_req.valid && !cfg_q |=> walk_attr.valid && walk_attr.page_hw_attributes == 2'b00
	) else $error("walk attribute driven while unsupported");

	a_walk_rsvd_zero: assert property (
		wr_access && sel == SEL_WALK_LO |=> (walk_ctrl_q & ~`WALK_WMASK) == `ZERO_WORD
	) else $error("walk control reserved bit set");

	a_base1_attr1: assert property (
		walk_req.valid && walk_req.base == BASE1 && cfg_q
		|=> walk_attr.page_hw_attributes[1] == $past(b1a1_exp)
	) else $error("base1 attribute 1 wrong");

	a_base1_attr0: assert property (
		walk_req.valid && walk_req.base == BASE1 && cfg_q
		|=> walk_attr.page_hw_attributes[0] == $past(b1a0_exp)
	) else $error("base1 attribute 0 wrong");

	a_base0_attr1: assert property (
		walk_req.valid && walk_req.base == BASE0 && cfg_q
		|=> walk_attr.page_hw_attributes[1] == $past(b0a1_exp)
	) else $error("base0 attribute 1 wrong");

	a_enable_clear_zero: assert property (
		walk_req.valid && walk_req.base == BASE0 && !walk_ctrl_q[`WALK_B0A1_EN]
		|=> !walk_attr.page_hw_attributes[1]
	) else $error("attribute driven with enable clear");

	a_base0_attr0: assert property (
		walk_req.valid && walk_req.base == BASE0 && cfg_q
		|=> walk_attr.page_hw_attributes[0] == $past(b0a0_exp)
	) else $error("base0 attribute 0 wrong");

	a_aux_rsvd_ignored: assert property (
		setup && !pwrite && sel == SEL_AUXC_LO
		|=> (prdata & ~`AUXC_WMASK) == `ZERO_WORD
	) else $error("aux control reserved bit reads nonzero");

	// A verdict of both kinds at once would let a refused write through.
	a_gate_exclusive: assert property (
		ctl_wr_allow |-> ctl_wr_req.valid && !ctl_wr_block
	) else $error("gate verdict not exclusive");

	a_walk_high_zero: assert property (
		setup && !pwrite && sel == SEL_WALK_HI |=> prdata == `ZERO_WORD && !pslverr
	) else $error("walk control high word not zero");

	a_status_cfg: assert property (
		setup && !pwrite && sel == SEL_STATUS |=> prdata[`STAT_CFG_BIT] == $past(cfg_q)
	) else $error("status support bit wrong");

endmodule : aux_sysreg_walk_attr_bank

// File: aux_bank_map.svh
// Register offsets, field positions and reset values of the auxiliary register bank.
`ifndef AUX_BANK_MAP_SVH
`define AUX_BANK_MAP_SVH

// ----------------------------------------------------------------
// Byte offsets on the APB bus
// ----------------------------------------------------------------
`define OFS_AUXC_LO     8'h00
`define OFS_AUXC_HI     8'h04
`define OFS_AFS0_L1     8'h08
`define OFS_AFS0_L2     8'h0C
`define OFS_AFS0_L3     8'h10
`define OFS_AFS1_L1     8'h14
`define OFS_AFS1_L2     8'h18
`define OFS_AFS1_L3     8'h1C
`define OFS_AIDR        8'h20
`define OFS_AMA_L1_LO   8'h24
`define OFS_AMA_L1_HI   8'h28
`define OFS_AMA_L2_LO   8'h2C
`define OFS_AMA_L2_HI   8'h30
`define OFS_AMA_L3_LO   8'h34
`define OFS_AMA_L3_HI   8'h38
`define OFS_WALK_LO     8'h3C
`define OFS_WALK_HI     8'h40
`define OFS_STATUS      8'h44

// ----------------------------------------------------------------
// Highest-level auxiliary control fields
// ----------------------------------------------------------------
`define AUXC_AUX_EN_BIT 0
`define AUXC_EXT_EN_BIT 1
`define AUXC_WMASK      32'h0000_0003
`define AUXC_RST        32'h0000_0000

// ----------------------------------------------------------------
// Walk attribute control fields
// ----------------------------------------------------------------
`define WALK_B1A1_VAL   13
`define WALK_B1A0_VAL   12
`define WALK_B0A1_VAL   9
`define WALK_B0A0_VAL   8
`define WALK_B1A1_EN    5
`define WALK_B1A0_EN    4
`define WALK_B0A1_EN    1
`define WALK_B0A0_EN    0
`define WALK_WMASK      32'h0000_3333
`define WALK_RST        32'h0000_0000

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define STAT_CFG_BIT    0
`define STAT_ATTR_LSB   1
`define STAT_BLOCK_BIT  3
`define ZERO_WORD       32'h0000_0000

`endif

// File: aux_bank_pkg.sv
// Types shared by the auxiliary register bank and its write gate.
package aux_bank_pkg;

	typedef enum logic [1:0] {
		LVL_KERNEL_NS = 2'h0,
		LVL_KERNEL_S  = 2'h1,
		LVL_HYP       = 2'h2,
		LVL_TOP       = 2'h3
	} level_e;

	typedef enum logic [2:0] {
		TGT_CORE_AUX        = 3'h0,
		TGT_CORE_AUX_SECOND = 3'h1,
		TGT_CLUSTER_AUX     = 3'h2,
		TGT_CORE_EXT        = 3'h3,
		TGT_CLUSTER_EXT     = 3'h4
	} ctl_target_e;

	typedef enum logic {
		BASE0 = 1'b0,
		BASE1 = 1'b1
	} table_base_e;

	typedef enum logic [3:0] {
		SEL_NONE     = 4'h0,
		SEL_AUXC_LO  = 4'h1,
		SEL_AUXC_HI  = 4'h2,
		SEL_FAULT    = 4'h3,
		SEL_IDENT    = 4'h4,
		SEL_INDIRECT = 4'h5,
		SEL_WALK_LO  = 4'h6,
		SEL_WALK_HI  = 4'h7,
		SEL_STATUS   = 4'h8
	} reg_sel_e;

	typedef struct packed {
		logic        valid;
		level_e      level;
		ctl_target_e target;
	} ctl_wr_req_s;

	typedef struct packed {
		logic        valid;
		table_base_e base;
	} walk_req_s;

	typedef struct packed {
		logic       valid;
		logic [1:0] page_hw_attributes;
	} walk_attr_s;

endpackage : aux_bank_pkg

// File: ctl_write_gate.sv
// Write permission check for the auxiliary and extended control registers.
`timescale 1ns/10ps
module ctl_write_gate (
	input  wire logic                       aux_ctrl_write_enable,
	input  wire logic                       ext_ctrl_write_enable,
	input  wire aux_bank_pkg::ctl_wr_req_s  req,
	output logic                            allow,
	output logic                            block
);
	import aux_bank_pkg::*;

	function automatic logic is_aux_target(input ctl_target_e t);
		return (t == TGT_CORE_AUX) || (t == TGT_CORE_AUX_SECOND) ||
			(t == TGT_CLUSTER_AUX);
	endfunction : is_aux_target

	function automatic logic is_ext_target(input ctl_target_e t);
		return (t == TGT_CORE_EXT) || (t == TGT_CLUSTER_EXT);
	endfunction : is_ext_target

	logic mid_level;
	logic granted;

	// Non-secure kernel writes are governed by the hypervisor-level enables,
	// which live outside this bank, so they are refused here.
	assign mid_level = (req.level == LVL_HYP) || (req.level == LVL_KERNEL_S);

	always_comb begin
		granted = 1'b0;
		if (req.level == LVL_TOP) begin
			granted = 1'b1;
		end else if (mid_level && is_aux_target(req.target)) begin
			granted = aux_ctrl_write_enable;
		end else if (mid_level && is_ext_target(req.target)) begin
			granted = ext_ctrl_write_enable;
		end
	end

	assign allow = req.valid & granted;
	assign block = req.valid & ~granted;

endmodule : ctl_write_gate

// File: aux_sysreg_walk_attr_bank_bench.sv
// Self-checking testbench for the auxiliary register bank with walk attribute control.
`timescale 1ns/10ps
`include "aux_bank_map.svh"
module aux_sysreg_walk_attr_bank_bench;
	import aux_bank_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        attr_support_pin;
	ctl_wr_req_s ctl_wr_req;
	logic        ctl_wr_allow;
	logic        ctl_wr_block;
	walk_req_s   walk_req;
	walk_attr_s  walk_attr;
	int          err_count;
	int          tests_run;
	logic [31:0] rd;
	logic        er;
	logic [31:0] walk_tab [7];

	aux_sysreg_walk_attr_bank #(.ADDR_W(8)) uut (
		.pclk             (pclk),
		.presetn          (presetn),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.pstrb            (pstrb),
		.pready           (pready),
		.prdata           (prdata),
		.pslverr          (pslverr),
		.attr_support_pin (attr_support_pin),
		.ctl_wr_req       (ctl_wr_req),
		.ctl_wr_allow     (ctl_wr_allow),
		.ctl_wr_block     (ctl_wr_block),
		.walk_req         (walk_req),
		.walk_attr        (walk_attr)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// The master never assumes a latency; only the watchdog ends a stuck wait.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic gate(input level_e lv, input int tg, input logic exp);
		@(posedge pclk);
		ctl_wr_req <= '{valid: 1'b1, level: lv, target: ctl_target_e'(tg)};
		@(negedge pclk);
		check("allow", {31'h0, ctl_wr_allow}, {31'h0, exp});
		check("block", {31'h0, ctl_wr_block}, {31'h0, ~exp});
	endtask : gate

	function automatic logic [1:0] attr_exp(input logic [31:0] w, input logic b1, input logic c);
		if (b1) begin
			return {w[13] & w[5], w[12] & w[4]} & {c, c};
		end
		return {w[9] & w[1], w[8] & w[0]} & {c, c};
	endfunction : attr_exp

	// Two walks back to back: base 1 then base 0 on consecutive edges.
	task automatic walk2(input logic [31:0] w, input logic c);
		@(posedge pclk);
		walk_req <= '{valid: 1'b1, base: BASE1};
		@(posedge pclk);
		walk_req <= '{valid: 1'b1, base: BASE0};
		#1;
		check("walk valid", {31'h0, walk_attr.valid}, 32'h1);
		check("base1 attr", {30'h0, walk_attr.page_hw_attributes}, {30'h0, attr_exp(w, 1, c)});
		@(posedge pclk);
		walk_req <= '{valid: 1'b0, base: BASE0};
		#1;
		check("base0 attr", {30'h0, walk_attr.page_hw_attributes}, {30'h0, attr_exp(w, 0, c)});
		@(posedge pclk);
		#1;
		check("walk pulse", {31'h0, walk_attr.valid}, 32'h0);
	endtask : walk2

	// ----------------------------------------------------------------
	// Clock, reset and watchdog
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		tests_run = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		attr_support_pin = 1'b1;
		ctl_wr_req = '0;
		walk_req = '0;
		walk_tab = '{32'h0000_3333, 32'h0000_2222, 32'h0000_1111, 32'h0000_3300,
			32'h0000_0033, 32'h0000_2130, 32'h0000_1203};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_AUXC_LO, 32'h0);
		check("aux ctrl reset", rd, 32'h0);
		apb(1'b0, `OFS_WALK_LO, 32'h0);
		check("walk ctrl reset", rd, 32'h0);
		for (int t = 0; t < 5; t++) begin
			gate(LVL_HYP, t, 1'b0);
			gate(LVL_KERNEL_S, t, 1'b0);
		end
		// Each enable alone, then both, so a swapped bit cannot hide.
		for (int e = 1; e < 4; e++) begin
			apb(1'b1, `OFS_AUXC_LO, 32'hFFFF_FFFC | e);
			apb(1'b0, `OFS_AUXC_LO, 32'h0);
			check("aux ctrl mask", rd, e);
			for (int t = 0; t < 5; t++) begin
				gate(LVL_KERNEL_NS, t, 1'b0);
				gate(LVL_TOP, t, 1'b1);
				gate(LVL_HYP, t, (t < 3) ? e[0] : e[1]);
				gate(LVL_KERNEL_S, t, (t < 3) ? e[0] : e[1]);
			end
		end
		for (int a = 8'h04; a <= 8'h40; a += 4) begin
			if (a != `OFS_WALK_LO) begin
				apb(1'b1, a[7:0], 32'hFFFF_FFFF);
				check("reserved write err", {31'h0, er}, 32'h0);
				apb(1'b0, a[7:0], 32'h0);
				check("reserved word", rd, 32'h0);
			end
		end
		apb(1'b1, `OFS_WALK_LO, 32'hFFFF_FFFF);
		apb(1'b0, `OFS_WALK_LO, 32'h0);
		check("walk ctrl mask", rd, 32'h0000_3333);
		foreach (walk_tab[i]) begin
			apb(1'b1, `OFS_WALK_LO, walk_tab[i]);
			walk2(walk_tab[i], 1'b1);
		end
		apb(1'b0, `OFS_STATUS, 32'h0);
		check("status walk", rd, {28'h0, 1'b0, attr_exp(walk_tab[6], 1'b0, 1'b1), 1'b1});
		// The support pin is synchronised, so it is held well past its two-flop delay.
		@(posedge pclk);
		attr_support_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		walk2(32'h0000_1203, 1'b0);
		apb(1'b0, `OFS_WALK_LO, 32'h0);
		check("walk ctrl kept", rd, 32'h0000_1203);
		gate(LVL_KERNEL_NS, 0, 1'b0);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check("status idle", rd, 32'h0000_0008);
		apb(1'b1, 8'h48, 32'hFFFF_FFFF);
		check("unmapped write err", {31'h0, er}, 32'h1);
		apb(1'b0, 8'hFC, 32'h0);
		check("unmapped read err", {31'h0, er}, 32'h1);
		print_verdict();
	end

endmodule : aux_sysreg_walk_attr_bank_bench
